/* include/smac_pkg.sv */
/*
 * Shared definitions for the signed multiply-accumulate datapath: operation codes,
 * condition codes, flag positions, field widths, and the request and answer structs.
 * Assumes a decoder and register file in the same clock domain.
 */
package smac_pkg;

	// ------------------------------------------------------------
	// widths and field positions
	// ------------------------------------------------------------
	localparam int WORD_W      = 32;
	localparam int HALF_W      = 16;
	localparam int ROT_HALF    = 16;
	localparam int FLAG_N_POS  = 31;
	localparam int FLAG_Z_POS  = 30;
	localparam int FLAG_C_POS  = 29;
	localparam int FLAG_V_POS  = 28;
	localparam int FLAG_Q_POS  = 27;
	localparam int SFLAG_POS   = 20;
	localparam logic [3:0] NO_ACC_FIELD = 4'hf;
	localparam logic [31:0] STATUS_RST = 32'h0000_0000;

	// ------------------------------------------------------------
	// operations and conditions
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SMAC_OP_DUAL_HALF_MAC = 3'h0,
		SMAC_OP_DUAL_HALF_MUL = 3'h1,
		SMAC_OP_LONG_MAC      = 3'h2,
		SMAC_OP_HALF_LONG_MAC = 3'h3
	} smac_op_t;

	typedef enum logic [3:0] {
		SMAC_CC_EQ = 4'h0, SMAC_CC_NE = 4'h1, SMAC_CC_CS = 4'h2, SMAC_CC_CC = 4'h3,
		SMAC_CC_MI = 4'h4, SMAC_CC_PL = 4'h5, SMAC_CC_VS = 4'h6, SMAC_CC_VC = 4'h7,
		SMAC_CC_HI = 4'h8, SMAC_CC_LS = 4'h9, SMAC_CC_GE = 4'ha, SMAC_CC_LT = 4'hb,
		SMAC_CC_GT = 4'hc, SMAC_CC_LE = 4'hd, SMAC_CC_AL = 4'he, SMAC_CC_NV = 4'hf
	} smac_cond_t;

	// ------------------------------------------------------------
	// request from decoder and answer to register file
	// ------------------------------------------------------------
	typedef struct packed {
		smac_op_t    op;
		smac_cond_t  cond;
		logic        flag_update_bit;
		logic        halfword_swap_sel;
		logic        first_half_sel;
		logic        second_half_sel;
		logic [3:0]  accum_field;
		logic [31:0] mult_a_reg;
		logic [31:0] mult_b_reg;
		logic [31:0] accum_reg;
		logic [31:0] acc_high_reg;
		logic [31:0] acc_low_reg;
	} smac_req_t;

	typedef struct packed {
		logic        wr_single;
		logic        wr_pair;
		logic [31:0] dest_reg;
		logic [31:0] res_high;
		logic [31:0] res_low;
	} smac_res_t;

endpackage

/* verilog/smac_mul16.sv */
/*
 * Signed 16x16 multiplier producing a full 32-bit product.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module smac_mul16 (
	// operands
	input  wire logic signed [15:0] op_a,
	input  wire logic signed [15:0] op_b,
	// product
	output logic signed [31:0]      prod
);
	import smac_pkg::*;

	// full-width product, cannot overflow 32 bits
	assign prod = op_a * op_b;
endmodule

/* verilog/smac_datapath.sv */
/*
 * Signed multiply-accumulate datapath: dual halfword, long and halfword long forms.
 * Assumes the decoder presents one request per issue pulse with operands already
 * read from the register file; the result appears one cycle later.
 */
// Notes on behaviour
// - swap select rotates second operand right by 16 before the dual multiply
// - dual form adds accumulator and low and high signed half products
// - signed overflow of the accumulating dual sum sets the sticky overflow latch
// - dual form leaves N, Z, C and V unchanged
// - dual encoding with accumulator field all ones runs as non-accumulating multiply
// - any early termination would be decided on the second operand
// - register write strobes and flag updates happen only when the condition passes
// - long form adds signed 32x32 product to the 64-bit register pair
// - upper word is product high plus old upper plus low carry
// - with flag update, negative flag takes bit 31 of upper result
// - with flag update, zero set only when both result words are zero
// - without flag update, long form leaves status word untouched
// - long form never changes carry or overflow flags
// - all operands are read before either destination word is written
// - halfword long form takes one selected signed half of each source
// - halfword long form sign-extends product and adds to the pair
// - halfword long form wraps modulo 2^64 with no overflow detect
// - half select 0 picks bits 15:0, 1 picks bits 31:16
// - halfword long form leaves every flag including the latch unchanged
`timescale 1ns/1ps
module smac_datapath (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// request from decoder
	input  wire logic              issue,
	input  wire smac_pkg::smac_req_t req,
	// status word write port
	input  wire logic              status_wr,
	input  wire logic [31:0]       status_wdata,
	// results
	output logic                   res_valid,
	output smac_pkg::smac_res_t    res,
	output logic [31:0]            status_word,
	output logic                   busy
);
	import smac_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// picks a signed half of a word
	function automatic logic signed [15:0] pick_half(input logic [31:0] w, input logic sel);
		pick_half = sel ? w[WORD_W-1:HALF_W] : w[HALF_W-1:0];
	endfunction

	// condition evaluation against N Z C V
	function automatic logic cond_pass(input smac_cond_t c, input logic [31:0] s);
		logic n;
		logic z;
		logic cf;
		logic v;
		n  = s[FLAG_N_POS];
		z  = s[FLAG_Z_POS];
		cf = s[FLAG_C_POS];
		v  = s[FLAG_V_POS];
		unique case (c)
			SMAC_CC_EQ: cond_pass = z;
			SMAC_CC_NE: cond_pass = !z;
			SMAC_CC_CS: cond_pass = cf;
			SMAC_CC_CC: cond_pass = !cf;
			SMAC_CC_MI: cond_pass = n;
			SMAC_CC_PL: cond_pass = !n;
			SMAC_CC_VS: cond_pass = v;
			SMAC_CC_VC: cond_pass = !v;
			SMAC_CC_HI: cond_pass = cf && !z;
			SMAC_CC_LS: cond_pass = !cf || z;
			SMAC_CC_GE: cond_pass = (n == v);
			SMAC_CC_LT: cond_pass = (n != v);
			SMAC_CC_GT: cond_pass = !z && (n == v);
			SMAC_CC_LE: cond_pass = z || (n != v);
			SMAC_CC_AL: cond_pass = 1'b1;
			SMAC_CC_NV: cond_pass = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// operand selection
	// ------------------------------------------------------------
	logic [31:0]        b_eff;
	logic signed [31:0] prod_lo;
	logic signed [31:0] prod_hi;
	logic signed [31:0] prod_sel;
	logic signed [15:0] sel_a;
	logic signed [15:0] sel_b;
	smac_op_t           op_eff;
	logic               pass;

	// exchange halves of the second operand when asked
	assign b_eff = req.halfword_swap_sel ? {req.mult_b_reg[ROT_HALF-1:0], req.mult_b_reg[WORD_W-1:ROT_HALF]}
		: req.mult_b_reg;

	// accumulator field all ones turns dual mac into plain dual multiply
	assign op_eff = (req.op == SMAC_OP_DUAL_HALF_MAC && req.accum_field == NO_ACC_FIELD)
		? SMAC_OP_DUAL_HALF_MUL : req.op;

	assign sel_a = pick_half(req.mult_a_reg, req.first_half_sel);
	assign sel_b = pick_half(req.mult_b_reg, req.second_half_sel);
	assign pass  = cond_pass(req.cond, status_word);

	// low halves product; the dual path uses its own pair of multipliers
	smac_mul16 u_mul_lo (
		.op_a (req.mult_a_reg[HALF_W-1:0]),
		.op_b (b_eff[HALF_W-1:0]),
		.prod (prod_lo)
	);

	// high halves product
	smac_mul16 u_mul_hi (
		.op_a (req.mult_a_reg[WORD_W-1:HALF_W]),
		.op_b (b_eff[WORD_W-1:HALF_W]),
		.prod (prod_hi)
	);

	// selected halves product for the halfword long form
	smac_mul16 u_mul_sel (
		.op_a (sel_a),
		.op_b (sel_b),
		.prod (prod_sel)
	);

	// ------------------------------------------------------------
	// arithmetic
	// ------------------------------------------------------------
	logic signed [33:0] dual_wide;
	logic [31:0]        dual_sum;
	logic               dual_ovf;
	logic signed [63:0] long_prod;
	logic [32:0]        low_sum;
	logic [31:0]        long_hi;
	logic [63:0]        hl_sum;

	// dual sum kept wide so overflow is seen exactly
	always_comb begin
		dual_wide = 34'(signed'(prod_lo)) + 34'(signed'(prod_hi));
		if (op_eff == SMAC_OP_DUAL_HALF_MAC) begin
			dual_wide = dual_wide + 34'(signed'(req.accum_reg));
		end
		dual_sum = dual_wide[WORD_W-1:0];
		// overflow when the wide sum does not fit 32 signed bits
		dual_ovf = (dual_wide[33:31] != {3{dual_wide[31]}});
	end

	// long form: low word with carry, then high word
	always_comb begin
		long_prod = signed'(req.mult_a_reg) * signed'(req.mult_b_reg);
		low_sum   = {1'b0, long_prod[WORD_W-1:0]} + {1'b0, req.acc_low_reg};
		long_hi   = long_prod[63:WORD_W] + req.acc_high_reg + {31'h0000_0000, low_sum[WORD_W]};
	end

	// halfword long: sign-extended product, plain modulo 2^64 add
	assign hl_sum = {req.acc_high_reg, req.acc_low_reg} + 64'(signed'(prod_sel));

	// ------------------------------------------------------------
	// result registers; all operands were consumed above, so
	// a destination equal to a source cannot disturb the sum
	// ------------------------------------------------------------
	smac_res_t res_d;
	logic      fire;

	assign fire = issue && pass;

	always_comb begin
		res_d = '0;
		unique case (op_eff)
			SMAC_OP_DUAL_HALF_MAC,
			SMAC_OP_DUAL_HALF_MUL: begin
				res_d.wr_single = fire;
				res_d.dest_reg  = dual_sum;
			end
			SMAC_OP_LONG_MAC: begin
				res_d.wr_pair  = fire;
				res_d.res_low  = low_sum[WORD_W-1:0];
				res_d.res_high = long_hi;
			end
			SMAC_OP_HALF_LONG_MAC: begin
				res_d.wr_pair  = fire;
				res_d.res_low  = hl_sum[WORD_W-1:0];
				res_d.res_high = hl_sum[63:WORD_W];
			end
			// idle cycles may carry an undefined operation code
			default: begin
				res_d = '0;
			end
		endcase
	end

	// result word register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			res <= '0;
		end else begin
			res <= res_d;
		end
	end

	// one-cycle answer pulse for every issue, taken or not
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			res_valid <= 1'b0;
		end else begin
			res_valid <= issue;
		end
	end

	// single-cycle datapath never stalls the decoder
	assign busy = 1'b0;

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	logic [31:0] status_d;

	always_comb begin
		status_d = status_word;
		if (status_wr) begin
			status_d = status_wdata;
		end
		if (fire) begin
			unique case (op_eff)
				SMAC_OP_DUAL_HALF_MAC: begin
					// only the latch may move; set beats a same-cycle write
					if (dual_ovf) begin
						status_d[FLAG_Q_POS] = 1'b1;
					end
				end
				SMAC_OP_LONG_MAC: begin
					if (req.flag_update_bit) begin
						status_d[FLAG_N_POS] = long_hi[FLAG_N_POS];
						status_d[FLAG_Z_POS] = (long_hi == '0) && (low_sum[WORD_W-1:0] == '0);
					end
				end
				SMAC_OP_DUAL_HALF_MUL,
				SMAC_OP_HALF_LONG_MAC: begin
					status_d = status_d;
				end
				default: ;
			endcase
		end
	end

	// status register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			status_word <= STATUS_RST;
		end else begin
			status_word <= status_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_cond_gate: assert property (@(posedge mclk) disable iff (!nrst)
		(issue && !pass) |=> (!res.wr_single && !res.wr_pair))
		else $error("write issued with failing condition");

	a_dual_swap: assert property (@(posedge mclk) disable iff (!nrst)
		(op_eff == SMAC_OP_DUAL_HALF_MUL && fire && req.halfword_swap_sel) |=>
		(res.dest_reg == $past(32'(signed'(req.mult_a_reg[15:0]) * signed'(req.mult_b_reg[31:16])
		+ signed'(req.mult_a_reg[31:16]) * signed'(req.mult_b_reg[15:0])))))
		else $error("swapped dual product wrong");

	a_dual_sum: assert property (@(posedge mclk) disable iff (!nrst)
		(req.op == SMAC_OP_DUAL_HALF_MAC && req.accum_field != NO_ACC_FIELD && fire && !req.halfword_swap_sel) |=>
		(res.dest_reg == $past(req.accum_reg + 32'(signed'(req.mult_a_reg[15:0]) * signed'(req.mult_b_reg[15:0]))
		+ 32'(signed'(req.mult_a_reg[31:16]) * signed'(req.mult_b_reg[31:16])))))
		else $error("dual accumulate sum wrong");

	a_ovf_sets: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && op_eff == SMAC_OP_DUAL_HALF_MAC && dual_ovf) |=> status_word[FLAG_Q_POS])
		else $error("overflow latch not set");

	a_dual_flags: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && op_eff == SMAC_OP_DUAL_HALF_MAC && !status_wr) |=>
		(status_word[31:28] == $past(status_word[31:28])))
		else $error("dual form changed condition flags");

	a_long_pair: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && op_eff == SMAC_OP_LONG_MAC) |=> ({res.res_high, res.res_low} ==
		$past(64'(signed'(req.mult_a_reg) * signed'(req.mult_b_reg)) + {req.acc_high_reg, req.acc_low_reg})))
		else $error("long accumulate wrong");

	a_long_flags: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && op_eff == SMAC_OP_LONG_MAC && req.flag_update_bit && !status_wr) |=>
		(status_word[FLAG_N_POS] == res.res_high[31] && status_word[FLAG_Z_POS] == ({res.res_high, res.res_low} == '0)
		&& status_word[29:27] == $past(status_word[29:27])))
		else $error("long form flags wrong");

	a_long_noflag: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && op_eff == SMAC_OP_LONG_MAC && !req.flag_update_bit && !status_wr) |=> $stable(status_word))
		else $error("status changed without flag update");

	a_hl_flags: assert property (@(posedge mclk) disable iff (!nrst)
		(issue && op_eff == SMAC_OP_HALF_LONG_MAC && !status_wr) |=> $stable(status_word))
		else $error("halfword long form changed flags");

	a_q_sticky: assert property (@(posedge mclk) disable iff (!nrst)
		(status_word[FLAG_Q_POS] && !status_wr) |=> status_word[FLAG_Q_POS])
		else $error("overflow latch cleared without write");

	a_valid_pulse: assert property (@(posedge mclk) disable iff (!nrst)
		res_valid == $past(issue))
		else $error("answer pulse does not follow issue");

	a_idle_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		!issue |=> (!res.wr_single && !res.wr_pair))
		else $error("register write without issue");

	a_no_acc: assert property (@(posedge mclk) disable iff (!nrst)
		(req.op == SMAC_OP_DUAL_HALF_MAC && req.accum_field == NO_ACC_FIELD && fire && !req.halfword_swap_sel) |=>
		(res.dest_reg == $past(32'(signed'(req.mult_a_reg[15:0]) * signed'(req.mult_b_reg[15:0]))
		+ 32'(signed'(req.mult_a_reg[31:16]) * signed'(req.mult_b_reg[31:16])))))
		else $error("non-accumulating dual result wrong");

	a_hl_sum: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && op_eff == SMAC_OP_HALF_LONG_MAC) |=> ({res.res_high, res.res_low} ==
		$past({req.acc_high_reg, req.acc_low_reg}
		+ 64'(signed'(req.first_half_sel ? req.mult_a_reg[31:16] : req.mult_a_reg[15:0])
		* signed'(req.second_half_sel ? req.mult_b_reg[31:16] : req.mult_b_reg[15:0])))))
		else $error("halfword long sum wrong");

	a_pair_write: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && (op_eff == SMAC_OP_LONG_MAC || op_eff == SMAC_OP_HALF_LONG_MAC)) |=>
		(res.wr_pair && !res.wr_single))
		else $error("long form did not write the pair");

	a_single_write: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && (op_eff == SMAC_OP_DUAL_HALF_MAC || op_eff == SMAC_OP_DUAL_HALF_MUL)) |=>
		(res.wr_single && !res.wr_pair))
		else $error("dual form did not write one register");

	a_long_cv: assert property (@(posedge mclk) disable iff (!nrst)
		(fire && op_eff == SMAC_OP_LONG_MAC && !status_wr) |=>
		(status_word[FLAG_C_POS] == $past(status_word[FLAG_C_POS])
		&& status_word[FLAG_V_POS] == $past(status_word[FLAG_V_POS])))
		else $error("long form changed carry or overflow");

	a_status_load: assert property (@(posedge mclk) disable iff (!nrst)
		(status_wr && !fire) |=> (status_word == $past(status_wdata)))
		else $error("status write not taken");

endmodule

/* testbench/smac_dec_model.sv */
/*
 * Decoder and register file stand-in: presents one request or idle cycle per call.
 * Assumes the bench calls drive once per clock, just after the rising edge.
 */
`timescale 1ns/1ps
module smac_dec_model (
	// clock
	input  wire logic           mclk,
	// request to datapath
	output logic                issue,
	output smac_pkg::smac_req_t req,
	// status word write
	output logic                status_wr,
	output logic [31:0]         status_wdata
);
	import smac_pkg::*;
	// ------------------------------------------------------------
	// request driver
	// ------------------------------------------------------------
	// quiet values at time zero
	initial begin
		issue = 1'b0;
		req = '0;
		status_wr = 1'b0;
		status_wdata = 32'h0;
	end
	// idle cycles show inverted operands so stale data never passes for valid
	task automatic drive(input smac_req_t r, input logic iss, sw, input logic [31:0] wd);
		issue        <= iss;
		req          <= iss ? r : ~req;
		status_wr    <= sw;
		status_wdata <= sw ? wd : ~status_wdata;
	endtask
endmodule

/* testbench/tb_top.sv */
/*
 * Self-checking bench for the multiply-accumulate datapath: corner and random requests.
 * Assumes the decoder model drives all request inputs, one call per clock.
 */
`timescale 1ns/1ps
module tb_top;
	import smac_pkg::*;
	// ------------------------------------------------------------
	// signals and expectations
	// ------------------------------------------------------------
	logic        mclk;
	logic        nrst;
	logic        issue;
	smac_req_t   req;
	logic        status_wr;
	logic [31:0] status_wdata;
	logic        res_valid;
	smac_res_t   res;
	logic [31:0] status_word;
	logic        busy;
	int          miscompares = 0;
	int          num_checks = 0;
	logic        e_v = 1'b0;
	logic        e_s = 1'b0;
	logic        e_p = 1'b0;
	logic [31:0] e_d;
	logic [63:0] e_l;
	logic [31:0] e_st = STATUS_RST;

	smac_dec_model i_smac_dec_model (
		.mclk         (mclk),
		.issue        (issue),
		.req          (req),
		.status_wr    (status_wr),
		.status_wdata (status_wdata)
	);
	smac_datapath i_smac_datapath (
		.mclk         (mclk),
		.nrst         (nrst),
		.issue        (issue),
		.req          (req),
		.status_wr    (status_wr),
		.status_wdata (status_wdata),
		.res_valid    (res_valid),
		.res          (res),
		.status_word  (status_word),
		.busy         (busy)
	);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic wrap_up();
		if (miscompares == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(logic [63:0] got, logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// condition pass against a status word
	function automatic logic cond_ok(logic [3:0] c, logic [31:0] s);
		logic n, z, cy, v, t;
		n = s[FLAG_N_POS];
		z = s[FLAG_Z_POS];
		cy = s[FLAG_C_POS];
		v = s[FLAG_V_POS];
		case (c[3:1])
			3'h0: t = z;
			3'h1: t = cy;
			3'h2: t = n;
			3'h3: t = v;
			3'h4: t = cy & ~z;
			3'h5: t = (n == v);
			3'h6: t = ~z & (n == v);
			default: t = 1'b1;
		endcase
		return (c == 4'hf) ? 1'b0 : t ^ c[0];
	endfunction
	// bits: flag update, swap, first half, second half
	function automatic smac_req_t mk(logic [2:0] op, logic [3:0] cc, logic [3:0] bits, logic [3:0] af,
			logic [31:0] a, logic [31:0] b, logic [31:0] n, logic [63:0] hl);
		return smac_req_t'({op, cc, bits, af, a, b, n, hl});
	endfunction
	// independent values stand for distinct upper and lower registers
	function automatic smac_req_t rnd_req();
		logic [191:0] t;
		t = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		t[174] = 1'b0;
		return smac_req_t'(t[174:0]);
	endfunction
	// only an accumulating dual request moves the overflow latch
	function automatic logic acc_used(smac_req_t r);
		return r.op == SMAC_OP_DUAL_HALF_MAC && r.accum_field != NO_ACC_FIELD;
	endfunction
	// expected answer and status after one request
	task automatic predict(smac_req_t r, logic iss, logic sw, logic [31:0] wd);
		logic [31:0] b, acc;
		logic signed [33:0] sum;
		logic pass;
		pass = iss && cond_ok(r.cond, e_st);
		if (sw) e_st = wd;
		e_v = iss;
		e_s = 1'b0;
		e_p = 1'b0;
		if (pass && r.op <= SMAC_OP_DUAL_HALF_MUL) begin
			b = r.halfword_swap_sel ? {r.mult_b_reg[15:0], r.mult_b_reg[31:16]} : r.mult_b_reg;
			acc = (r.op == SMAC_OP_DUAL_HALF_MUL || r.accum_field == NO_ACC_FIELD) ? 32'h0 : r.accum_reg;
			sum = $signed(acc) + $signed(r.mult_a_reg[15:0]) * $signed(b[15:0])
				+ $signed(r.mult_a_reg[31:16]) * $signed(b[31:16]);
			e_s = 1'b1;
			e_d = sum[31:0];
			if (acc_used(r) && sum[33:31] != {3{sum[31]}}) e_st[FLAG_Q_POS] = 1'b1;
		end else if (pass && r.op == SMAC_OP_LONG_MAC) begin
			e_l = $signed({r.acc_high_reg, r.acc_low_reg}) + $signed(r.mult_a_reg) * $signed(r.mult_b_reg);
			e_p = 1'b1;
			if (r.flag_update_bit) begin
				e_st[FLAG_N_POS] = e_l[63];
				e_st[FLAG_Z_POS] = (e_l == 64'h0);
			end
		end else if (pass) begin
			e_l = $signed({r.acc_high_reg, r.acc_low_reg})
				+ $signed(r.first_half_sel ? r.mult_a_reg[31:16] : r.mult_a_reg[15:0])
				* $signed(r.second_half_sel ? r.mult_b_reg[31:16] : r.mult_b_reg[15:0]);
			e_p = 1'b1;
		end
	endtask
	// one clock: drive, then check the answer to the previous request
	task automatic step(smac_req_t r, logic iss, logic sw, logic [31:0] wd);
		@(posedge mclk);
		i_smac_dec_model.drive(r, iss, sw, wd);
		@(negedge mclk);
		chk(res_valid, e_v);
		chk({res.wr_single, res.wr_pair}, {e_s, e_p});
		if (e_s) chk(res.dest_reg, e_d);
		if (e_p) chk({res.res_high, res.res_low}, e_l);
		chk(status_word, e_st);
		chk(busy, 1'b0);
		predict(r, iss, sw, wd);
	endtask
	// ------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (3000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end
	initial begin
		nrst = 1'b0;
		void'($urandom(32'h73f2));
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		step(mk(0, SMAC_CC_AL, 4'h0, 4'h0, 32'h7fff_7fff, 32'h7fff_7fff, 32'h7fff_ffff, 0), 1, 1, 0);
		step(mk(0, SMAC_CC_AL, 4'h4, 4'hf, 32'h0002_0003, 32'h0005_0007, 32'h1234_5678, 0), 1, 0, 0);
		step(mk(2, SMAC_CC_AL, 4'h8, 4'h0, 32'h1, 32'hffff_ffff, 0, 64'h1), 1, 0, 0);
		step(mk(2, SMAC_CC_EQ, 4'h8, 4'h0, 32'h1, 32'h1, 0, 64'hffff_ffff), 1, 0, 0);
		step(mk(2, SMAC_CC_EQ, 4'h8, 4'h0, 32'h1, 32'h1, 0, 64'h5), 1, 0, 0);
		step(mk(3, SMAC_CC_AL, 4'hb, 4'h0, 32'h7fff_0000, 32'h7fff_0000, 0, 64'h7fff_ffff_ffff_ffff), 1, 0, 0);
		step(mk(2, SMAC_CC_AL, 4'h0, 4'h0, 32'h8000_0000, 32'h8000_0000, 0, 64'h0), 1, 0, 0);
		step(mk(0, SMAC_CC_NV, 4'h0, 4'h0, 32'h7fff_7fff, 32'h7fff_7fff, 32'h7fff_ffff, 0), 1, 0, 0);
		step(rnd_req(), 1'b0, 1'b1, 32'h0);
		repeat (600) begin
			step(rnd_req(), ($urandom % 5) != 0, ($urandom % 8) == 0, $urandom);
		end
		step(rnd_req(), 1'b0, 1'b0, 32'h0);
		wrap_up();
	end
endmodule
